// >>> rtl/aof_pkg.sv
package aof_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned AXES       = 3;
  localparam int unsigned RES_W      = 20;
  localparam int unsigned TRIM_W     = 16;
  localparam int unsigned WORD_W     = 24;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam int unsigned WORD_BYTES = 3;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] X_ACCEL_HIGH_ADDR = 8'h08;
  localparam logic [7:0] X_ACCEL_MID_ADDR  = 8'h09;
  localparam logic [7:0] X_ACCEL_LOW_ADDR  = 8'h0a;
  localparam logic [7:0] Y_ACCEL_HIGH_ADDR = 8'h0b;
  localparam logic [7:0] Y_ACCEL_MID_ADDR  = 8'h0c;
  localparam logic [7:0] Y_ACCEL_LOW_ADDR  = 8'h0d;
  localparam logic [7:0] Z_ACCEL_HIGH_ADDR = 8'h0e;
  localparam logic [7:0] Z_ACCEL_MID_ADDR  = 8'h0f;
  localparam logic [7:0] Z_ACCEL_LOW_ADDR  = 8'h10;
  localparam logic [7:0] QUEUE_READ_ADDR   = 8'h11;
  localparam logic [7:0] X_TRIM_HIGH_ADDR  = 8'h1e;
  localparam logic [7:0] X_TRIM_LOW_ADDR   = 8'h1f;
  localparam logic [7:0] Y_TRIM_HIGH_ADDR  = 8'h20;
  localparam logic [7:0] Y_TRIM_LOW_ADDR   = 8'h21;
  localparam logic [7:0] Z_TRIM_HIGH_ADDR  = 8'h22;
  localparam logic [7:0] Z_TRIM_LOW_ADDR   = 8'h23;

  ////////////////////////////////////////////////////////////////////////////
  // field layout and reset values
  localparam logic [3:0]       LOW_PAD     = 4'h0;
  localparam logic [7:0]       BYTE_RESET  = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET   = 20'h00000;
  localparam logic [1:0]       PHASE_FIRST = 2'h0;
  localparam logic [1:0]       PHASE_LAST  = 2'h2;
  localparam logic [7:0]       ADDR_RESET  = 8'h00;

  typedef struct packed {
    logic [RES_W-1:0] x;
    logic [RES_W-1:0] y;
    logic [RES_W-1:0] z;
  } aof_axes_s;

  typedef enum logic [3:0] {
    FEED_IDLE = 4'b0001,
    FEED_X    = 4'b0010,
    FEED_Y    = 4'b0100,
    FEED_Z    = 4'b1000
  } aof_feed_e;

endpackage

// >>> rtl/aof_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module aof_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,       // system clock
  input  wire logic             rst_n_i,     // async reset, active low
  input  wire logic             in_valid_i,  // word offered
  output logic                  in_ready_o,  // room for a word
  input  wire logic [WIDTH-1:0] in_data_i,   // word to store
  output logic                  out_valid_o, // head word present
  input  wire logic             out_ready_i, // head word taken
  output logic [WIDTH-1:0]      out_data_o,  // head word
  output logic [$clog2(DEPTH+1)-1:0] level_o // words stored
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;
  assign out_data_o  = mem[rd_ptr];
  assign level_o     = count;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/aof_trim_add.sv
`timescale 1ns/100ps
`default_nettype none
module aof_trim_add
  import aof_pkg::*;
(
  input  wire logic [RES_W-1:0]  raw_i,  // processed axis value
  input  wire logic [TRIM_W-1:0] trim_i, // signed trim, lsb at result bit 4
  output logic [RES_W-1:0]       sum_o   // trimmed axis value
);

  // wraps on overflow, like a plain twos-complement adder
  assign sum_o = raw_i + {trim_i, LOW_PAD};

endmodule
`default_nettype wire

// >>> rtl/aof_regs.sv
// Function
// - y result is 20 bits split 19:12, 11:4, and 3:0 in upper nibble.
// - z result uses the same split; low nibble of last byte reserved.
// - results are signed, left justified; unused low bits read zero.
// - queue reads deliver 24-bit words, most significant byte first.
// - a direct read of the queue port pops one word supplying the bytes.
// - sustained queue port reads pop a new word every third byte.
// - bursts starting at the queue port keep the pointer fixed.
// - queue port reached by increment returns zero, no pop, pointer moves on.
// - each axis gets a signed trim added after all other processing.
// - trim is high and low byte; trim bit 0 aligns with result bit 4.
// - trims read-write reset zero; results and queue port read-only zero.
// - x result uses the same layout starting at address 0x08.
`timescale 1ns/100ps
`default_nettype none
module aof_regs
  import aof_pkg::*;
(
  input  wire logic       clk_i,         // system clock, 100 MHz
  input  wire logic       rst_n_i,       // async reset, active low
  input  wire logic       samp_valid_i,  // processed sample offered
  output logic            samp_ready_o,  // feed idle; a sample offered now is taken
  input  wire aof_axes_s  samp_i,        // processed axis values
  input  wire logic       acc_valid_i,   // one register byte access
  input  wire logic       acc_first_i,   // first byte of a transaction
  input  wire logic       acc_write_i,   // byte is a write
  input  wire logic [7:0] acc_addr_i,    // start address, on first byte
  input  wire logic [7:0] acc_wdata_i,   // write byte
  output logic [7:0]      rdata_o,       // read byte
  output logic            rdata_valid_o, // read byte strobe
  output logic [7:0]      addr_ptr_o,    // current address pointer
  output logic [3:0]      queue_level_o  // words in the queue
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_trim(input logic [7:0] a);
    return (a >= X_TRIM_HIGH_ADDR) && (a <= Z_TRIM_LOW_ADDR);
  endfunction

  function automatic logic [2:0] trim_idx(input logic [7:0] a);
    logic [7:0] d;
    d = 8'(a - X_TRIM_HIGH_ADDR);
    return d[2:0];
  endfunction

  function automatic logic is_result(input logic [7:0] a);
    return (a >= X_ACCEL_HIGH_ADDR) && (a <= Z_ACCEL_LOW_ADDR);
  endfunction

  function automatic logic is_queue_port(input logic [7:0] a);
    return (a == QUEUE_READ_ADDR);
  endfunction

  // byte p of a three-byte word, most significant first
  function automatic logic [7:0] part_byte(input logic [WORD_W-1:0] w,
                                           input logic [1:0]        p);
    logic [7:0] b;
    b = w[23:16];
    if (p == 2'h1) begin
      b = w[15:8];
    end else if (p == 2'h2) begin
      b = w[7:0];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [RES_W-1:0]  raw_ax   [AXES];
  logic [RES_W-1:0]  trim_ax  [AXES];
  logic [RES_W-1:0]  res_reg  [AXES];
  logic [TRIM_W-1:0] trim_word [AXES];
  logic [7:0]        trim_reg [2*AXES];

  aof_feed_e         feed_reg;
  logic [1:0]        push_sel;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [WORD_W-1:0] fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  logic [7:0]        ptr_reg;
  logic [7:0]        ptr_next;
  logic              direct_reg;
  logic [1:0]        phase_reg;
  logic [WORD_W-1:0] hold_reg;
  logic [7:0]        cur_addr;
  logic              queue_direct;
  logic              rd_req;
  logic              wr_req;
  logic              queue_hit;
  logic              pop;
  logic [7:0]        queue_byte;
  logic [7:0]        res_off;
  logic [1:0]        res_axis;
  logic [1:0]        res_part;
  logic [7:0]        rd_byte;
  logic              samp_take;
  logic [2*AXES-1:0] trim_we;

  assign raw_ax[0] = samp_i.x;
  assign raw_ax[1] = samp_i.y;
  assign raw_ax[2] = samp_i.z;

  ////////////////////////////////////////////////////////////////////////////
  // trim adders, one per axis

  for (genvar a = 0; a < AXES; a++) begin : g_trim
    assign trim_word[a] = {trim_reg[2*a], trim_reg[2*a+1]};
    aof_trim_add u_add (
      .raw_i  (raw_ax[a]),
      .trim_i (trim_word[a]),
      .sum_o  (trim_ax[a])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample intake and queue feed

  // one sample at a time: the next waits until all three words are queued
  assign samp_ready_o = (feed_reg == FEED_IDLE);
  assign samp_take    = samp_valid_i && samp_ready_o;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feed_reg <= FEED_IDLE;
    end else begin
      unique case (feed_reg)
        FEED_IDLE: begin
          if (samp_valid_i) begin
            feed_reg <= FEED_X;
          end
        end
        FEED_X: begin
          if (fifo_in_ready) begin
            feed_reg <= FEED_Y;
          end
        end
        FEED_Y: begin
          if (fifo_in_ready) begin
            feed_reg <= FEED_Z;
          end
        end
        FEED_Z: begin
          if (fifo_in_ready) begin
            feed_reg <= FEED_IDLE;
          end
        end
        default: begin
          feed_reg <= FEED_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int a = 0; a < AXES; a++) begin
        res_reg[a] <= RES_RESET;
      end
    end else if (samp_take) begin
      for (int a = 0; a < AXES; a++) begin
        res_reg[a] <= trim_ax[a];
      end
    end
  end

  always_comb begin
    push_sel = 2'h0;
    if (feed_reg == FEED_Y) begin
      push_sel = 2'h1;
    end else if (feed_reg == FEED_Z) begin
      push_sel = 2'h2;
    end
  end

  assign fifo_in_valid = (feed_reg != FEED_IDLE);
  assign fifo_in_data  = {res_reg[push_sel], LOW_PAD};

  aof_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (QUEUE_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (queue_level_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  assign cur_addr     = acc_first_i ? acc_addr_i : ptr_reg;
  assign queue_direct = acc_first_i ? 1'b1 : direct_reg;
  assign rd_req       = acc_valid_i && !acc_write_i;
  assign wr_req       = acc_valid_i && acc_write_i;
  // a write to the port never pops, so only reads qualify
  assign queue_hit    = rd_req && is_queue_port(cur_addr) && queue_direct;

  // an empty queue at a word boundary yields zero and pops nothing
  assign pop            = queue_hit && (phase_reg == PHASE_FIRST) && fifo_out_valid;
  assign fifo_out_ready = pop;

  always_comb begin
    queue_byte = BYTE_RESET;
    if (phase_reg != PHASE_FIRST) begin
      queue_byte = part_byte(hold_reg, phase_reg);
    end else if (fifo_out_valid) begin
      queue_byte = part_byte(fifo_out_data, PHASE_FIRST);
    end
  end

  always_comb begin
    res_off  = 8'(cur_addr - X_ACCEL_HIGH_ADDR);
    res_axis = 2'(res_off / 8'd3);
    res_part = 2'(res_off % 8'd3);
  end

  always_comb begin
    rd_byte = BYTE_RESET;
    if (is_queue_port(cur_addr)) begin
      if (queue_direct) begin
        rd_byte = queue_byte;
      end
      // reached by increment: stays zero
    end else if (is_result(cur_addr)) begin
      rd_byte = part_byte({res_reg[res_axis], LOW_PAD}, res_part);
    end else if (is_trim(cur_addr)) begin
      rd_byte = trim_reg[trim_idx(cur_addr)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address pointer

  // wraps past 0xff; nothing is mapped up there
  always_comb begin
    ptr_next = 8'(cur_addr + 8'h01);
    if (is_queue_port(cur_addr) && queue_direct) begin
      ptr_next = cur_addr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_reg <= ADDR_RESET;
    end else if (acc_valid_i) begin
      ptr_reg <= ptr_next;
    end
  end

  // remembers whether the open transaction began at the queue port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direct_reg <= 1'b0;
    end else if (acc_valid_i && acc_first_i) begin
      direct_reg <= is_queue_port(acc_addr_i);
    end
  end

  assign addr_ptr_o = ptr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // queue word sequencing

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg <= '0;
    end else if (pop) begin
      hold_reg <= fifo_out_data;
    end
  end

  // phase survives between transactions so single reads finish a word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= PHASE_FIRST;
    end else if (queue_hit && (pop || (phase_reg != PHASE_FIRST))) begin
      phase_reg <= (phase_reg == PHASE_LAST) ? PHASE_FIRST
                                             : 2'(phase_reg + 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trim registers

  // one-hot byte enables; writes anywhere else leave every register alone
  always_comb begin
    trim_we = '0;
    if (wr_req && is_trim(cur_addr)) begin
      trim_we[trim_idx(cur_addr)] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2 * AXES; i++) begin
        trim_reg[i] <= BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < 2 * AXES; i++) begin
        if (trim_we[i]) begin
          trim_reg[i] <= acc_wdata_i;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read return

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= rd_req;
    end
  end

  // data holds between reads so a slow host can sample it late
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= BYTE_RESET;
    end else if (rd_req) begin
      rdata_o <= rd_byte;
    end
  end

endmodule
`default_nettype wire

// >>> verif/aof_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module aof_regs_checker
  import aof_pkg::*;
(
  input wire logic       clk_i,         // clock
  input wire logic       rst_n_i,       // reset
  input wire logic       acc_valid_i,   // access
  input wire logic       acc_first_i,   // first byte
  input wire logic       acc_write_i,   // write
  input wire logic [7:0] acc_addr_i,    // start address
  input wire logic [7:0] rdata_o,       // read byte
  input wire logic       rdata_valid_o, // read strobe
  input wire logic [7:0] addr_ptr_o,    // pointer
  input wire logic [3:0] queue_level_o  // level
);
  logic [7:0] eff;
  logic       rd;
  logic       hold;
  logic       s11_reg;
  assign eff  = acc_first_i ? acc_addr_i : addr_ptr_o;
  assign rd   = acc_valid_i && !acc_write_i;
  assign hold = eff == QUEUE_READ_ADDR && (acc_first_i || s11_reg);
  // a transaction begun at the queue port pins the pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) s11_reg <= 1'b0;
    else if (acc_valid_i && acc_first_i) s11_reg <= acc_addr_i == QUEUE_READ_ADDR;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_strobe; rd |=> rdata_valid_o; endproperty
  a_strobe: assert property (p_strobe) else $error("read strobe missing");
  property p_nostrobe; !rd |=> !rdata_valid_o; endproperty
  a_nostrobe: assert property (p_nostrobe) else $error("stray read strobe");
  property p_hold; rd && hold && acc_first_i |=> addr_ptr_o == QUEUE_READ_ADDR; endproperty
  a_hold: assert property (p_hold) else $error("pointer left queue port");
  property p_step; acc_valid_i && !hold |=> addr_ptr_o == $past(eff) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_inczero; rd && eff == QUEUE_READ_ADDR && !hold |=> rdata_o == 8'h00; endproperty
  a_inczero: assert property (p_inczero) else $error("increment read not zero");
  property p_nopop; !(rd && hold) |=> queue_level_o >= $past(queue_level_o); endproperty
  a_nopop: assert property (p_nopop) else $error("queue popped unasked");
  property p_nibble;
    rd && (eff == X_ACCEL_LOW_ADDR || eff == Y_ACCEL_LOW_ADDR || eff == Z_ACCEL_LOW_ADDR)
      |=> rdata_o[3:0] == 4'h0;
  endproperty
  a_nibble: assert property (p_nibble) else $error("low nibble not zero");
  property p_unmap;
    rd && eff > QUEUE_READ_ADDR && eff < X_TRIM_HIGH_ADDR |=> rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_hold: cover property (rd && hold && !acc_first_i);
  c_inc: cover property (rd && eff == QUEUE_READ_ADDR && !hold);
  c_full: cover property (queue_level_o == 4'h8);
endmodule
bind aof_regs aof_regs_checker aof_regs_checker_inst (.clk_i, .rst_n_i, .acc_valid_i,
  .acc_first_i, .acc_write_i, .acc_addr_i, .rdata_o, .rdata_valid_o, .addr_ptr_o,
  .queue_level_o);
`default_nettype wire

// >>> verif/aof_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module aof_host_model (
  input  wire logic       clk_i,         // clock
  input  wire logic       slow_i,        // idle gap before bytes
  input  wire logic [7:0] rdata_i,       // read byte
  input  wire logic       rdata_valid_i, // read strobe
  output logic            valid_o,       // access
  output logic            first_o,       // first byte
  output logic            write_o,       // write
  output logic [7:0]      addr_o,        // start address
  output logic [7:0]      wdata_o        // write byte
);
  // released lines other than valid_o and write_o flip so a stale value cannot pass for a live one;
  // the idle cycle keeps two transfers from meeting in one time step
  task automatic idle();
    valid_o = 1'b0;
    first_o = ~first_o;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
    @(negedge clk_i);
  endtask
  // caller enters at a falling edge; the answer is sampled one cycle on
  task automatic xfer(input logic f, input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    if (slow_i) begin
      idle();
    end
    valid_o = 1'b1;
    first_o = f;
    write_o = w;
    addr_o  = a;
    wdata_o = d;
    @(negedge clk_i);
    r = (w || rdata_valid_i) ? rdata_i : 8'hxx;
  endtask
  initial begin
    first_o = 1'b0;
    write_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    idle();
  end
endmodule
`default_nettype wire

// >>> verif/aof_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module aof_regs_test;
  import aof_pkg::*;
  logic        clk, rst_n, sv, sr, slow, av, af, aw, rv;
  logic [7:0]  aa, wd, rdat, ptr, r, d;
  logic [3:0]  lvl;
  logic [63:0] rnd;
  aof_axes_s   smp;
  logic [19:0] res[3];
  logic [15:0] tr[3];
  logic [23:0] q[$];
  logic [23:0] cur;
  int          failures, comparisons, seed, ph;
  aof_regs aof_regs_inst (.clk_i(clk), .rst_n_i(rst_n), .samp_valid_i(sv), .samp_ready_o(sr),
    .samp_i(smp), .acc_valid_i(av), .acc_first_i(af), .acc_write_i(aw), .acc_addr_i(aa),
    .acc_wdata_i(wd), .rdata_o(rdat), .rdata_valid_o(rv), .addr_ptr_o(ptr),
    .queue_level_o(lvl));
  aof_host_model aof_host_model_inst (.clk_i(clk), .slow_i(slow), .rdata_i(rdat),
    .rdata_valid_i(rv), .valid_o(av), .first_o(af), .write_o(aw), .addr_o(aa), .wdata_o(wd));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] reg_exp(input logic [7:0] a);
    int k;
    k = int'(a);
    if (k >= 8 && k <= 16) return 8'({res[(k - 8) / 3], 4'h0} >> (8 * (2 - (k - 8) % 3)));
    if (k >= 30 && k <= 35) return 8'(tr[(k - 30) / 2] >> (8 * (1 - (k - 30) % 2)));
    return 8'h00;
  endfunction
  // an empty queue at a word boundary yields zero and keeps the phase
  function automatic logic [7:0] q_exp();
    logic [7:0] b;
    if (ph == 0) begin
      if (q.size() == 0) return 8'h00;
      cur = q.pop_front();
    end
    b = cur[23 - 8 * ph -: 8];
    ph = (ph + 1) % 3;
    return b;
  endfunction
  task automatic rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      aof_host_model_inst.xfer(i == 0, 1'b0, a, 8'h00, r);
      if (a == QUEUE_READ_ADDR) check(r, q_exp());
      else check(r, reg_exp(8'(a + i)));
    end
    aof_host_model_inst.idle();
  endtask
  task automatic push(input aof_axes_s s);
    int t;
    t = 0;
    smp = s;
    sv = 1'b1;
    while (sr !== 1'b1 && t < 500) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    sv = 1'b0;
    smp = ~s;
    if (t == 500) failures++;
    for (int k = 0; k < 3; k++) begin
      res[k] = s[59 - 20 * k -: 20] + {tr[k], 4'h0};
      q.push_back({res[k], 4'h0});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h8f3af65c;
    failures = 0;
    comparisons = 0;
    ph = 0;
    rst_n = 1'b0;
    sv = 1'b0;
    slow = 1'b0;
    smp = '0;
    res = '{default: 20'h0};
    tr = '{default: 16'h0};
    repeat (10) @(negedge clk);
    check({lvl, ptr, sr, rv}, {4'h0, 8'h00, 1'b1, 1'b0});
    rst_n = 1'b1;
    @(negedge clk);
    rd(X_ACCEL_HIGH_ADDR, 28);
    for (int p = 0; p < 2; p++) begin
      slow = p[0];
      for (int i = 0; i < 6; i++) begin
        d = 8'($random(seed));
        aof_host_model_inst.xfer(i == 0, 1'b1, X_TRIM_HIGH_ADDR, d, r);
        if (i % 2 == 1) tr[i / 2][7:0] = d;
        else tr[i / 2][15:8] = d;
      end
      aof_host_model_inst.idle();
      aof_host_model_inst.xfer(1'b1, 1'b1, Y_ACCEL_HIGH_ADDR, 8'hff, r);
      aof_host_model_inst.xfer(1'b1, 1'b1, QUEUE_READ_ADDR, 8'hff, r);
      aof_host_model_inst.idle();
      rnd = {$random(seed), $random(seed)};
      push(p == 0 ? {20'h80000, 20'h7ffff, 20'hfffff} : rnd[59:0]);
      rd(X_ACCEL_HIGH_ADDR, 28);
      check(lvl, 24'h3);
      rd(QUEUE_READ_ADDR, 9);
      check(ptr, QUEUE_READ_ADDR);
    end
    rnd = {$random(seed), $random(seed)};
    push(rnd[59:0]);
    repeat (3) rd(QUEUE_READ_ADDR, 1);
    for (int j = 0; j < 3; j++) begin
      rnd = {$random(seed), $random(seed)};
      push(rnd[59:0]);
    end
    repeat (4) @(negedge clk);
    check({lvl, sr}, {4'h8, 1'b0});
    rd(QUEUE_READ_ADDR, 34);
    check(lvl, 24'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
